// ==== core/dra_pkg.sv ====
// Package with constants shared by the dictionary access design
package dra_pkg;

  // ==========================================================================
  // Dictionary indexes
  localparam logic [15:0] IDX_PDO_COMM   = 16'h0020;
  localparam logic [15:0] IDX_PDO_MAP    = 16'h0021;
  localparam logic [15:0] IDX_SDO_PARAM  = 16'h0022;
  localparam logic [15:0] IDX_IDENTITY   = 16'h0023;
  localparam logic [15:0] IDX_UREG_TYPES = 16'h0040;
  localparam logic [15:0] IDX_DEV_TYPE   = 16'h1000;

  // ==========================================================================
  // Object codes
  localparam logic [7:0] OBJ_NULL      = 8'h00;
  localparam logic [7:0] OBJ_DOMAIN    = 8'h02;
  localparam logic [7:0] OBJ_DEFTYPE   = 8'h05;
  localparam logic [7:0] OBJ_DEFSTRUCT = 8'h06;
  localparam logic [7:0] OBJ_VAR       = 8'h07;
  localparam logic [7:0] OBJ_ARRAY     = 8'h08;
  localparam logic [7:0] OBJ_RECORD    = 8'h09;

  // ==========================================================================
  // Data type indexes and descriptor word layout
  localparam logic [15:0] DT_U8  = 16'h0005;
  localparam logic [15:0] DT_U16 = 16'h0006;
  localparam logic [15:0] DT_U32 = 16'h0007;
  localparam logic [7:0]  DESC_RSVD = 8'h00;

  // ==========================================================================
  // Sub-indexes and record sizes
  localparam logic [7:0] SUB_COUNT      = 8'h00;
  localparam logic [7:0] SUB_DESC       = 8'hFF;
  localparam logic [7:0] SUB_ONE        = 8'h01;
  localparam logic [7:0] SUB_TWO        = 8'h02;
  localparam logic [7:0] SUB_THREE      = 8'h03;
  localparam logic [7:0] PDO_COMM_COUNT = 8'h06;
  localparam logic [7:0] PDO_MAP_MAX    = 8'h04;
  localparam logic [7:0] SDO_COUNT      = 8'h03;
  localparam logic [7:0] IDENT_COUNT    = 8'h04;
  localparam logic [7:0] UREG_TYPES     = 8'h0E;

  // ==========================================================================
  // Access types of user registers
  localparam logic [3:0] ACC_FULL   = 4'h1;
  localparam logic [3:0] ACC_UPPER  = 4'h2;
  localparam logic [3:0] ACC_LOWER  = 4'h3;
  localparam logic [3:0] ACC_U24    = 4'h4;
  localparam logic [3:0] ACC_I24    = 4'h5;
  localparam logic [3:0] ACC_BYTE   = 4'h6;
  localparam logic [3:0] ACC_OR32   = 4'h7;
  localparam logic [3:0] ACC_ORUP   = 4'h8;
  localparam logic [3:0] ACC_ORLO   = 4'h9;
  localparam logic [3:0] ACC_OR8    = 4'hA;
  localparam logic [3:0] ACC_CLR32  = 4'hB;
  localparam logic [3:0] ACC_CLRUP  = 4'hC;
  localparam logic [3:0] ACC_CLRLO  = 4'hD;
  localparam logic [3:0] ACC_CLR8   = 4'hE;

  // ==========================================================================
  // Request sources and answer codes
  localparam logic [1:0] SRC_LOCAL  = 2'h0;
  localparam logic [1:0] SRC_REMOTE = 2'h1;
  localparam logic [1:0] SRC_PDO    = 2'h2;

  localparam logic [2:0] ERR_NONE      = 3'h0;
  localparam logic [2:0] ERR_NO_OBJ    = 3'h1;
  localparam logic [2:0] ERR_NO_SUB    = 3'h2;
  localparam logic [2:0] ERR_READ_ONLY = 3'h3;
  localparam logic [2:0] ERR_WR_ONLY   = 3'h4;
  localparam logic [2:0] ERR_NOT_MAP   = 3'h5;
  localparam logic [2:0] ERR_RANGE     = 3'h6;

  // Reset values of the writable records
  localparam logic [31:0] RST_WORD = 32'h0000_0000;
  localparam logic [7:0]  RST_BYTE = 8'h00;

endpackage

// ==== core/dra_acc_if.sv ====
// Interface carrying a user register access between the main block and the access unit
interface dra_acc_if;
  logic [3:0]  acc_type;
  logic [31:0] old_val;
  logic [31:0] wdata;
  logic [31:0] new_val;
  logic [31:0] rd_val;
  logic        type_ok;
  logic        write_only;

  modport main (
    output acc_type,
    output old_val,
    output wdata,
    input  new_val,
    input  rd_val,
    input  type_ok,
    input  write_only
  );

  modport unit (
    input  acc_type,
    input  old_val,
    input  wdata,
    output new_val,
    output rd_val,
    output type_ok,
    output write_only
  );
endinterface

// ==== core/dra_access_unit.sv ====
// Combinational merge of one user register access by access type
module dra_access_unit
  import dra_pkg::*;
(
  dra_acc_if.unit acc
);

  // ==========================================================================
  // Access type decode
  // Operands are taken as plain unsigned bit patterns; only the signed 24-bit type (ACC_I24) sign extends bit 23
  always_comb begin
    acc.type_ok    = (acc.acc_type >= ACC_FULL) && (acc.acc_type <= ACC_CLR8);
    acc.write_only = (acc.acc_type >= ACC_OR32);
    acc.rd_val     = RST_WORD;
    acc.new_val    = acc.old_val;
    case (acc.acc_type)
      ACC_FULL: begin
        acc.rd_val  = acc.old_val;
        acc.new_val = acc.wdata;
      end
      ACC_UPPER: begin
        acc.rd_val  = {16'h0000, acc.old_val[31:16]};
        acc.new_val = {acc.wdata[15:0], acc.old_val[15:0]};
      end
      ACC_LOWER: begin
        acc.rd_val  = {16'h0000, acc.old_val[15:0]};
        acc.new_val = {acc.old_val[31:16], acc.wdata[15:0]};
      end
      ACC_U24: begin
        acc.rd_val  = {8'h00, acc.old_val[23:0]};
        acc.new_val = {8'h00, acc.wdata[23:0]};
      end
      ACC_I24: begin
        acc.rd_val  = {{8{acc.old_val[23]}}, acc.old_val[23:0]};
        acc.new_val = {{8{acc.wdata[23]}}, acc.wdata[23:0]};
      end
      ACC_BYTE: begin
        acc.rd_val  = {24'h000000, acc.old_val[7:0]};
        acc.new_val = {acc.old_val[31:8], acc.wdata[7:0]};
      end
      ACC_OR32:  acc.new_val = acc.old_val | acc.wdata;
      ACC_ORUP:  acc.new_val = acc.old_val | {acc.wdata[15:0], 16'h0000};
      ACC_ORLO:  acc.new_val = acc.old_val | {16'h0000, acc.wdata[15:0]};
      ACC_OR8:   acc.new_val = acc.old_val | {24'h000000, acc.wdata[7:0]};
      ACC_CLR32: acc.new_val = acc.old_val & ~acc.wdata;
      ACC_CLRUP: acc.new_val = acc.old_val & ~{acc.wdata[15:0], 16'h0000};
      ACC_CLRLO: acc.new_val = acc.old_val & ~{16'h0000, acc.wdata[15:0]};
      ACC_CLR8:  acc.new_val = acc.old_val & ~{24'h000000, acc.wdata[7:0]};
      default:   acc.new_val = acc.old_val;
    endcase
  end

endmodule

// ==== core/dra_dictionary.sv ====
// Object dictionary access block: descriptors, PDO and SDO records, user registers
module dra_dictionary
  import dra_pkg::*;
#(
  parameter int          NUM_UREG      = 8,
  parameter int          REG_AW        = 3,
  parameter logic [7:0]  UREG_RO_MASK  = 8'h80,
  parameter logic [31:0] DEV_TYPE_WORD = 32'h0000_0ABC  // Arbitrary value
) (
  input  wire logic              i_ref_clk,
  input  wire logic              i_resetn,
  input  wire logic              i_req_valid,
  input  wire logic              i_req_write,
  input  wire logic [1:0]        i_req_source,
  input  wire logic [15:0]       i_req_index,
  input  wire logic [7:0]        i_req_sub,
  input  wire logic [REG_AW-1:0] i_req_reg,
  input  wire logic [31:0]       i_req_wdata,
  output logic                   o_rsp_valid,
  output logic                   o_rsp_err,
  output logic [2:0]             o_rsp_code,
  output logic [31:0]            o_rsp_data
);

  // ==========================================================================
  // Reset release
  logic [1:0] rst_sync;
  logic       rst_n;

  // Release is delayed two edges so that every flop leaves reset together
  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      rst_sync <= 2'b00;
    end else begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end
  assign rst_n = rst_sync[1];

  // ==========================================================================
  // Storage
  logic [31:0] ureg [NUM_UREG];
  logic [7:0]  map_count;
  logic [31:0] map_entry [PDO_MAP_MAX];
  logic [31:0] sdo_rx_id;
  logic [31:0] sdo_tx_id;
  logic [7:0]  sdo_client;

  // ==========================================================================
  // Decode functions
  // Object code of an index; unknown indexes answer as null entries
  function automatic logic [7:0] obj_code(input logic [15:0] idx);
    if (idx == IDX_DEV_TYPE) begin
      obj_code = OBJ_VAR;
    end else if (idx == IDX_PDO_COMM || idx == IDX_PDO_MAP ||
                 idx == IDX_SDO_PARAM || idx == IDX_IDENTITY) begin
      obj_code = OBJ_DEFSTRUCT;
    end else if (idx == IDX_UREG_TYPES) begin
      obj_code = OBJ_DEFSTRUCT;
    end else begin
      obj_code = OBJ_NULL;
    end
  endfunction

  // Complex entries are the only ones that carry count and descriptor subs
  function automatic logic is_complex(input logic [7:0] code);
    is_complex = (code == OBJ_ARRAY) || (code == OBJ_RECORD) || (code == OBJ_DEFSTRUCT);
  endfunction

  // Field type of a sub-index within the PDO communication layout
  function automatic logic [15:0] comm_field(input logic [7:0] sub);
    if (sub == SUB_ONE) begin
      comm_field = DT_U32;
    end else if (sub == SUB_THREE || sub == 8'h05) begin
      comm_field = DT_U16;
    end else begin
      comm_field = DT_U8;
    end
  endfunction

  // ==========================================================================
  // Access unit
  dra_acc_if acc ();
  logic [REG_AW-1:0] sel;
  logic              sel_ok;
  logic              sel_ro;

  assign sel            = i_req_reg;
  assign sel_ok         = (32'(i_req_reg) < NUM_UREG);
  assign sel_ro         = UREG_RO_MASK[sel];
  assign acc.acc_type   = i_req_sub[3:0];
  assign acc.old_val    = ureg[sel];
  assign acc.wdata      = i_req_wdata;

  dra_access_unit u_access (
    .acc (acc.unit)
  );

  // ==========================================================================
  // Request decode
  logic [7:0]  req_code;
  logic        next_err;
  logic [2:0]  next_code;
  logic [31:0] next_data;
  logic        next_ureg_wr;
  logic        next_map_wr;
  logic        next_sdo_wr;
  logic        is_type_sub;

  assign req_code    = obj_code(i_req_index);
  assign is_type_sub = (i_req_sub != SUB_COUNT) && (i_req_sub != SUB_DESC);

  // Every source takes the same path; only the device type refuses PDO use
  always_comb begin
    next_code    = ERR_NONE;
    next_data    = RST_WORD;
    next_ureg_wr = 1'b0;
    next_map_wr  = 1'b0;
    next_sdo_wr  = 1'b0;
    if (req_code == OBJ_NULL) begin
      next_code = ERR_NO_OBJ;
    end else if (i_req_index == IDX_DEV_TYPE) begin
      if (i_req_source == SRC_PDO) begin
        next_code = ERR_NOT_MAP;
      end else if (i_req_sub != SUB_COUNT) begin
        next_code = ERR_NO_SUB;
      end else if (i_req_write) begin
        next_code = ERR_READ_ONLY;
      end else begin
        next_data = DEV_TYPE_WORD;
      end
    end else if (i_req_sub == SUB_DESC) begin
      if (i_req_write || !is_complex(req_code)) begin
        next_code = i_req_write ? ERR_READ_ONLY : ERR_NO_SUB;
      end else begin
        next_data = {DESC_RSVD, i_req_index, req_code};
      end
    end else if (i_req_index == IDX_UREG_TYPES && is_type_sub) begin
      // User register access, same for local, remote and PDO requests
      if (!acc.type_ok || !sel_ok || i_req_sub > UREG_TYPES) begin
        next_code = ERR_NO_SUB;
      end else if (!i_req_write && acc.write_only) begin
        next_code = ERR_WR_ONLY;
      end else if (i_req_write && sel_ro) begin
        next_code = ERR_READ_ONLY;
      end else if (i_req_write) begin
        next_ureg_wr = 1'b1;
      end else begin
        next_data = acc.rd_val;
      end
    end else if (i_req_sub == SUB_COUNT) begin
      if (i_req_index == IDX_PDO_MAP) begin
        if (!i_req_write) begin
          next_data = {24'h000000, map_count};
        end else if (i_req_wdata > {24'h000000, PDO_MAP_MAX}) begin
          next_code = ERR_RANGE;
        end else begin
          next_map_wr = 1'b1;
        end
      end else if (i_req_write) begin
        next_code = ERR_READ_ONLY;
      end else if (i_req_index == IDX_PDO_COMM) begin
        next_data = {24'h000000, PDO_COMM_COUNT};
      end else if (i_req_index == IDX_SDO_PARAM) begin
        next_data = {24'h000000, SDO_COUNT};
      end else if (i_req_index == IDX_IDENTITY) begin
        next_data = {24'h000000, IDENT_COUNT};
      end else begin
        next_data = {24'h000000, UREG_TYPES};
      end
    end else if (i_req_index == IDX_PDO_COMM && i_req_sub <= PDO_COMM_COUNT) begin
      if (i_req_write) begin
        next_code = ERR_READ_ONLY;
      end else begin
        next_data = {16'h0000, comm_field(i_req_sub)};
      end
    end else if (i_req_index == IDX_PDO_MAP && i_req_sub <= PDO_MAP_MAX) begin
      if (i_req_write) begin
        next_map_wr = 1'b1;
      end else begin
        next_data = map_entry[i_req_sub[1:0] - 2'd1];
      end
    end else if (i_req_index == IDX_SDO_PARAM && i_req_sub <= SDO_COUNT) begin
      if (i_req_write) begin
        next_sdo_wr = 1'b1;
      end else if (i_req_sub == SUB_ONE) begin
        next_data = sdo_rx_id;
      end else if (i_req_sub == SUB_TWO) begin
        next_data = sdo_tx_id;
      end else begin
        next_data = {24'h000000, sdo_client};
      end
    end else begin
      next_code = ERR_NO_SUB;
    end
    next_err = (next_code != ERR_NONE);
  end

  // ==========================================================================
  // Answer registers
  always_ff @(posedge i_ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      o_rsp_valid <= 1'b0;
      o_rsp_err   <= 1'b0;
      o_rsp_code  <= ERR_NONE;
      o_rsp_data  <= RST_WORD;
    end else begin
      o_rsp_valid <= i_req_valid;
      o_rsp_err   <= i_req_valid && next_err;
      o_rsp_code  <= i_req_valid ? next_code : ERR_NONE;
      o_rsp_data  <= (i_req_valid && !next_err) ? next_data : RST_WORD;
    end
  end

  // ==========================================================================
  // User registers
  // A refused request never reaches the write strobe, so the target stays put
  always_ff @(posedge i_ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < NUM_UREG; i++) begin
        ureg[i] <= RST_WORD;
      end
    end else if (i_req_valid && next_ureg_wr) begin
      ureg[sel] <= acc.new_val;
    end
  end

  // ==========================================================================
  // PDO mapping record
  always_ff @(posedge i_ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      map_count <= RST_BYTE;
      for (int i = 0; i < PDO_MAP_MAX; i++) begin
        map_entry[i] <= RST_WORD;
      end
    end else if (i_req_valid && next_map_wr) begin
      if (i_req_sub == SUB_COUNT) begin
        map_count <= i_req_wdata[7:0];
      end else begin
        map_entry[i_req_sub[1:0] - 2'd1] <= i_req_wdata;
      end
    end
  end

  // ==========================================================================
  // SDO parameter record
  always_ff @(posedge i_ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      sdo_rx_id  <= RST_WORD;
      sdo_tx_id  <= RST_WORD;
      sdo_client <= RST_BYTE;
    end else if (i_req_valid && next_sdo_wr) begin
      if (i_req_sub == SUB_ONE) begin
        sdo_rx_id <= i_req_wdata;
      end else if (i_req_sub == SUB_TWO) begin
        sdo_tx_id <= i_req_wdata;
      end else begin
        sdo_client <= i_req_wdata[7:0];
      end
    end
  end

  // ==========================================================================
  // Checks
  logic [REG_AW-1:0] last_sel;
  logic [31:0]       last_old;
  logic [31:0]       last_wdata;

  // Snapshot of the previous request, read only by the checks
  always_ff @(posedge i_ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      last_sel   <= '0;
      last_old   <= RST_WORD;
      last_wdata <= RST_WORD;
    end else begin
      last_sel   <= sel;
      last_old   <= ureg[sel];
      last_wdata <= i_req_wdata;
    end
  end

  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!rst_n);

  logic ureg_wr_req;
  assign ureg_wr_req = i_req_valid && i_req_write && (i_req_index == IDX_UREG_TYPES) &&
                       sel_ok && !sel_ro;

  desc_word_a: assert property (
    i_req_valid && !i_req_write && i_req_index == IDX_PDO_MAP && i_req_sub == SUB_DESC
    |=> !o_rsp_err && o_rsp_data == {DESC_RSVD, IDX_PDO_MAP, OBJ_DEFSTRUCT})
    else $error("descriptor word wrong");
  type_count_a: assert property (
    i_req_valid && !i_req_write && i_req_index == IDX_UREG_TYPES && i_req_sub == SUB_COUNT
    |=> o_rsp_data == 32'h0000_000E)
    else $error("access type count wrong");
  or_full_a: assert property (
    ureg_wr_req && i_req_sub == 8'h07 |=> ureg[last_sel] == (last_old | last_wdata))
    else $error("full word OR wrong");
  clr_low_a: assert property (
    ureg_wr_req && i_req_sub == 8'h0E
    |=> ureg[last_sel] == (last_old & ~{24'h000000, last_wdata[7:0]}))
    else $error("low byte clear wrong");
  signed_write_a: assert property (
    ureg_wr_req && i_req_sub == 8'h05
    |=> ureg[last_sel] == {{8{last_wdata[23]}}, last_wdata[23:0]})
    else $error("signed 24 bit write wrong");
  unsigned_write_a: assert property (
    ureg_wr_req && i_req_sub == 8'h04 |=> ureg[last_sel][31:24] == 8'h00)
    else $error("unsigned 24 bit write wrong");
  bad_type_a: assert property (
    i_req_valid && i_req_index == IDX_UREG_TYPES && i_req_sub > 8'h0E && i_req_sub != SUB_DESC
    |=> o_rsp_err && ureg[last_sel] == last_old)
    else $error("bad access type accepted");
  wr_only_a: assert property (
    i_req_valid && !i_req_write && i_req_index == IDX_UREG_TYPES && i_req_sub >= 8'h07 &&
    i_req_sub <= 8'h0E && sel_ok |=> o_rsp_err && o_rsp_code == ERR_WR_ONLY)
    else $error("write-only type read");
  dev_pdo_a: assert property (
    i_req_valid && i_req_index == IDX_DEV_TYPE && (i_req_source == SRC_PDO || (i_req_write && i_req_sub == SUB_COUNT))
    |=> o_rsp_err && (o_rsp_code == ERR_READ_ONLY || o_rsp_code == ERR_NOT_MAP))
    else $error("device type not protected");
  answer_time_a: assert property (
    i_req_valid |=> o_rsp_valid ##0 (o_rsp_err == (o_rsp_code != ERR_NONE)))
    else $error("answer not one cycle later");

endmodule

// ==== verif/dra_requester.sv ====
// Requester model standing for the local command path, a remote node or the PDO path
module dra_requester
  import dra_pkg::*;
(
  input  wire logic        i_ref_clk,
  input  wire logic        i_rsp_valid,
  input  wire logic        i_rsp_err,
  input  wire logic [2:0]  i_rsp_code,
  input  wire logic [31:0] i_rsp_data,
  output logic             o_req_valid,
  output logic             o_req_write,
  output logic [1:0]       o_req_source,
  output logic [15:0]      o_req_index,
  output logic [7:0]       o_req_sub,
  output logic [2:0]       o_req_reg,
  output logic [31:0]      o_req_wdata
);
  timeunit 1ns;
  timeprecision 1ps;

  // ==========================================================================
  // Idle request lines at time zero
  initial begin
    o_req_valid  = 1'b0;
    o_req_write  = 1'b0;
    o_req_source = SRC_LOCAL;
    o_req_index  = 16'h0000;
    o_req_sub    = 8'h00;
    o_req_reg    = 3'h0;
    o_req_wdata  = 32'h0000_0000;
  end

  // ==========================================================================
  // One request, one answer; the strobe drops for two edges so no signal is set twice in a step
  task automatic xfer(input logic w, input logic [1:0] s, input logic [15:0] idx, input logic [7:0] sub,
                      input logic [2:0] rg, input logic [31:0] wd,
                      output logic got, output logic e, output logic [2:0] c, output logic [31:0] d);
    @(posedge i_ref_clk);
    o_req_valid  <= 1'b1;
    o_req_write  <= w;
    o_req_source <= s;
    o_req_index  <= idx;
    o_req_sub    <= sub;
    o_req_reg    <= rg;
    o_req_wdata  <= wd;
    @(posedge i_ref_clk);
    o_req_valid <= 1'b0;
    o_req_wdata <= ~wd;  // Stale data is not left on the lines
    got = 1'b0;
    e   = 1'b0;
    c   = 3'h0;
    d   = 32'h0000_0000;
    // Answer is looked for in a bounded number of cycles
    for (int n = 0; n < 4 && got == 1'b0; n++) begin
      @(posedge i_ref_clk);
      if (i_rsp_valid === 1'b1) begin
        got = 1'b1;
        e   = i_rsp_err;
        c   = i_rsp_code;
        d   = i_rsp_data;
      end
    end
  endtask
endmodule

// ==== verif/dictionary_register_access_bench.sv ====
// Self-checking bench for the dictionary access block
module dictionary_register_access_bench;
  import dra_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;

  localparam logic [31:0] DEV_WORD = 32'h0000_5A5A;  // Arbitrary value
  logic        i_ref_clk;
  logic        i_resetn;
  logic        req_valid, req_write, rsp_valid, rsp_err;
  logic [1:0]  req_source;
  logic [15:0] req_index;
  logic [7:0]  req_sub;
  logic [2:0]  req_reg, rsp_code;
  logic [31:0] req_wdata, rsp_data;
  int          fails;
  int          samples_checked;
  int          cycles;

  // ==========================================================================
  // Clock, design and requester
  initial begin
    i_ref_clk = 1'b0;
    forever #10 i_ref_clk = ~i_ref_clk;
  end

  dra_dictionary #(.DEV_TYPE_WORD(DEV_WORD)) dut (.i_ref_clk(i_ref_clk), .i_resetn(i_resetn),
    .i_req_valid(req_valid), .i_req_write(req_write), .i_req_source(req_source), .i_req_index(req_index),
    .i_req_sub(req_sub), .i_req_reg(req_reg), .i_req_wdata(req_wdata), .o_rsp_valid(rsp_valid),
    .o_rsp_err(rsp_err), .o_rsp_code(rsp_code), .o_rsp_data(rsp_data));

  dra_requester req (.i_ref_clk(i_ref_clk), .i_rsp_valid(rsp_valid), .i_rsp_err(rsp_err),
    .i_rsp_code(rsp_code), .i_rsp_data(rsp_data), .o_req_valid(req_valid), .o_req_write(req_write),
    .o_req_source(req_source), .o_req_index(req_index), .o_req_sub(req_sub), .o_req_reg(req_reg),
    .o_req_wdata(req_wdata));

  // ==========================================================================
  // Closing report
  task automatic print_verdict();
    $display("Checks made: %0d, mismatches: %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // One access compared with its expected code and data; the error flag follows the code
  task automatic chk(input logic w, input logic [1:0] s, input logic [15:0] idx, input logic [7:0] sub,
                     input logic [2:0] rg, input logic [31:0] wd, input logic [2:0] ec, input logic [31:0] ed);
    logic        got, e;
    logic [2:0]  c;
    logic [31:0] d;
    req.xfer(w, s, idx, sub, rg, wd, got, e, c, d);
    samples_checked++;
    if (got !== 1'b1 || e !== (ec != ERR_NONE) || c !== ec || d !== ed) begin
      fails++;
      $display("Error at %0t: got %h/%h expected %h/%h", $time, c, d, ec, ed);
    end
  endtask

  // Hang guard: the whole sequence needs well under a thousand cycles
  always @(posedge i_ref_clk) begin
    cycles++;
    if (cycles == 3000) begin
      fails++;
      print_verdict();
    end
  end

  // ==========================================================================
  // Main sequence
  initial begin
    fails = 0;
    samples_checked = 0;
    cycles = 0;
    i_resetn = 1'b0;
    repeat (6) @(posedge i_ref_clk);
    i_resetn <= 1'b1;
    repeat (3) @(posedge i_ref_clk);
    // Descriptors and records
    chk(0, SRC_LOCAL, IDX_UREG_TYPES, 8'h00, 3'h0, 32'h0, ERR_NONE, 32'h0000_000E);
    chk(0, SRC_LOCAL, IDX_UREG_TYPES, 8'hFF, 3'h0, 32'h0, ERR_NONE, 32'h0000_4006);
    chk(0, SRC_REMOTE, IDX_PDO_MAP, 8'hFF, 3'h0, 32'h0, ERR_NONE, 32'h0000_2106);
    chk(0, SRC_LOCAL, IDX_PDO_COMM, 8'h00, 3'h0, 32'h0, ERR_NONE, 32'h0000_0006);
    chk(0, SRC_LOCAL, IDX_IDENTITY, 8'h00, 3'h0, 32'h0, ERR_NONE, 32'h0000_0004);
    chk(1, SRC_LOCAL, IDX_PDO_MAP, 8'h00, 3'h0, 32'h4, ERR_NONE, 32'h0);
    chk(1, SRC_LOCAL, IDX_PDO_MAP, 8'h00, 3'h0, 32'h5, ERR_RANGE, 32'h0);
    chk(0, SRC_LOCAL, IDX_PDO_MAP, 8'h00, 3'h0, 32'h0, ERR_NONE, 32'h0000_0004);
    chk(1, SRC_LOCAL, IDX_PDO_MAP, 8'h04, 3'h0, 32'hA5A5_5A5A, ERR_NONE, 32'h0);
    chk(0, SRC_LOCAL, IDX_PDO_MAP, 8'h04, 3'h0, 32'h0, ERR_NONE, 32'hA5A5_5A5A);
    chk(1, SRC_LOCAL, IDX_SDO_PARAM, 8'h02, 3'h0, 32'h0000_05C1, ERR_NONE, 32'h0);
    chk(1, SRC_LOCAL, IDX_SDO_PARAM, 8'h03, 3'h0, 32'h0000_0012, ERR_NONE, 32'h0);
    chk(0, SRC_LOCAL, IDX_SDO_PARAM, 8'h02, 3'h0, 32'h0, ERR_NONE, 32'h0000_05C1);
    chk(0, SRC_LOCAL, IDX_SDO_PARAM, 8'h03, 3'h0, 32'h0, ERR_NONE, 32'h0000_0012);
    chk(0, SRC_LOCAL, IDX_SDO_PARAM, 8'h00, 3'h0, 32'h0, ERR_NONE, 32'h0000_0003);
    $display("Test descriptors done");
    // Device type word: constant, read-only, never process data; then an unknown index refused
    chk(0, SRC_REMOTE, IDX_DEV_TYPE, 8'h00, 3'h0, 32'h0, ERR_NONE, DEV_WORD);
    chk(1, SRC_LOCAL, IDX_DEV_TYPE, 8'h00, 3'h0, 32'h1, ERR_READ_ONLY, 32'h0);
    chk(0, SRC_PDO, IDX_DEV_TYPE, 8'h00, 3'h0, 32'h0, ERR_NOT_MAP, 32'h0);
    chk(0, SRC_LOCAL, 16'h0999, 8'h00, 3'h0, 32'h0, ERR_NO_OBJ, 32'h0);
    $display("Test device type done");
    // User register access types, sources varied, each request waiting for its answer
    chk(1, SRC_LOCAL, IDX_UREG_TYPES, 8'h01, 3'h2, 32'h1234_5678, ERR_NONE, 32'h0);
    chk(0, SRC_REMOTE, IDX_UREG_TYPES, 8'h01, 3'h2, 32'h0, ERR_NONE, 32'h1234_5678);
    chk(0, SRC_PDO, IDX_UREG_TYPES, 8'h02, 3'h2, 32'h0, ERR_NONE, 32'h0000_1234);
    chk(0, SRC_LOCAL, IDX_UREG_TYPES, 8'h03, 3'h2, 32'h0, ERR_NONE, 32'h0000_5678);
    chk(1, SRC_LOCAL, IDX_UREG_TYPES, 8'h02, 3'h2, 32'h0000_ABCD, ERR_NONE, 32'h0);
    chk(1, SRC_LOCAL, IDX_UREG_TYPES, 8'h03, 3'h2, 32'h0000_00EF, ERR_NONE, 32'h0);
    chk(0, SRC_LOCAL, IDX_UREG_TYPES, 8'h01, 3'h2, 32'h0, ERR_NONE, 32'hABCD_00EF);
    chk(1, SRC_LOCAL, IDX_UREG_TYPES, 8'h04, 3'h2, 32'h0080_0001, ERR_NONE, 32'h0);
    chk(0, SRC_LOCAL, IDX_UREG_TYPES, 8'h01, 3'h2, 32'h0, ERR_NONE, 32'h0080_0001);
    chk(1, SRC_REMOTE, IDX_UREG_TYPES, 8'h05, 3'h2, 32'h0080_0001, ERR_NONE, 32'h0);
    chk(0, SRC_LOCAL, IDX_UREG_TYPES, 8'h01, 3'h2, 32'h0, ERR_NONE, 32'hFF80_0001);
    chk(1, SRC_LOCAL, IDX_UREG_TYPES, 8'h06, 3'h2, 32'h0000_015A, ERR_NONE, 32'h0);
    chk(0, SRC_LOCAL, IDX_UREG_TYPES, 8'h06, 3'h2, 32'h0, ERR_NONE, 32'h0000_005A);
    chk(1, SRC_PDO, IDX_UREG_TYPES, 8'h07, 3'h2, 32'h0000_000F, ERR_NONE, 32'h0);
    chk(1, SRC_REMOTE, IDX_UREG_TYPES, 8'h08, 3'h2, 32'h0000_0001, ERR_NONE, 32'h0);
    chk(1, SRC_LOCAL, IDX_UREG_TYPES, 8'h09, 3'h2, 32'h0000_0200, ERR_NONE, 32'h0);
    chk(1, SRC_LOCAL, IDX_UREG_TYPES, 8'h0A, 3'h2, 32'hFFFF_FF80, ERR_NONE, 32'h0);
    chk(0, SRC_LOCAL, IDX_UREG_TYPES, 8'h01, 3'h2, 32'h0, ERR_NONE, 32'hFF81_02DF);
    chk(1, SRC_PDO, IDX_UREG_TYPES, 8'h0B, 3'h2, 32'h0000_000F, ERR_NONE, 32'h0);
    chk(1, SRC_LOCAL, IDX_UREG_TYPES, 8'h0C, 3'h2, 32'h0000_8000, ERR_NONE, 32'h0);
    chk(1, SRC_LOCAL, IDX_UREG_TYPES, 8'h0D, 3'h2, 32'h0000_0300, ERR_NONE, 32'h0);
    chk(1, SRC_REMOTE, IDX_UREG_TYPES, 8'h0E, 3'h2, 32'hFFFF_FFF0, ERR_NONE, 32'h0);
    chk(0, SRC_LOCAL, IDX_UREG_TYPES, 8'h01, 3'h2, 32'h0, ERR_NONE, 32'h7F81_0000);
    chk(0, SRC_LOCAL, IDX_UREG_TYPES, 8'h07, 3'h2, 32'h0, ERR_WR_ONLY, 32'h0);
    chk(1, SRC_LOCAL, IDX_UREG_TYPES, 8'h07, 3'h7, 32'h0000_0001, ERR_READ_ONLY, 32'h0);
    chk(1, SRC_LOCAL, IDX_UREG_TYPES, 8'h0F, 3'h2, 32'hFFFF_FFFF, ERR_NO_SUB, 32'h0);
    chk(1, SRC_LOCAL, IDX_UREG_TYPES, 8'h11, 3'h2, 32'h0000_0001, ERR_NO_SUB, 32'h0);
    chk(0, SRC_LOCAL, IDX_UREG_TYPES, 8'h01, 3'h2, 32'h0, ERR_NONE, 32'h7F81_0000);
    $display("Test user registers done");
    print_verdict();
  end
endmodule
